/* logic/wsw_pkg.sv */
// Constants, register map and carrier types for the watchdog and sleep/wake-up block.
// Assumes a single 50 MHz pclk domain and an APB completer with 32-bit data.
//
// Operation
// - Watchdog runs from its own free-running tick, never stopped by sleep.
// - Watchdog expiry while running issues a full device reset.
// - Watchdog expiry while asleep wakes the device and execution continues.
// - Cleared watchdog configuration bit disables the watchdog; software cannot re-enable.
// - Without prescaler the watchdog expires after a nominal 18 ms.
// - Option register can assign the prescaler, dividing up to 1:128.
// - Clear-watchdog or sleep clears watchdog counter and assigned prescaler.
// - Timeout flag is cleared whenever the watchdog expires.
// - Sleep clears watchdog, clears power-down flag, sets timeout flag, stops oscillator.
// - During sleep every I/O pin holds its previous drive state.
// - Watchdog reset is internal and never drives the external reset pin.
// - Sleep ends on external reset, watchdog, or enabled interrupt; only pin resets.
// - Power-down flag is set at power-up and cleared by sleep.
// - Sleep execution prefetches the instruction at the next address.
// - A source wakes only if individually enabled; global enable is irrelevant.
// - Global enable clear continues in line; set runs prefetched then vectors 0004h.
// - Flag and enable both set at sleep means immediate wake after sleep.
// - Any wake-up from sleep clears the watchdog counter.
// - Interrupt entry pushes only the return address; nothing else is saved.
// - Taking an interrupt clears global enable, pushes return, loads vector.
// - Interrupt flags set on events regardless of any enable bit.

package wsw_pkg;

  // ****************************************************************
  // Register indices; byte address is four times the index.
  // ****************************************************************
  localparam logic [7:0] IDX_STATUS = 8'h03;
  localparam logic [7:0] IDX_INTERRUPT_CONTROL = 8'h0B;
  localparam logic [7:0] IDX_PERIPHERAL_IRQ_FLAGS = 8'h0C;
  localparam logic [7:0] IDX_OPTION_CONTROL = 8'h81;
  localparam logic [7:0] IDX_PERIPHERAL_IRQ_ENABLES = 8'h8C;
  localparam int ADDR_W = 12;

  // ****************************************************************
  // Field positions and reset values.
  // ****************************************************************
  localparam int IC_GLOBAL_IRQ_ENABLE = 7;
  localparam int IC_PERIPHERAL_IRQ_ENABLE = 6;
  localparam int IC_TIMER_OVERFLOW_IRQ_ENABLE = 5;
  localparam int IC_EDGE_PIN_IRQ_ENABLE = 4;
  localparam int IC_PORT_CHANGE_IRQ_ENABLE = 3;
  localparam int IC_TIMER_OVERFLOW_FLAG = 2;
  localparam int IC_EDGE_PIN_FLAG = 1;
  localparam int IC_PORT_CHANGE_FLAG = 0;
  localparam int PF_COMPARATOR = 6;
  localparam int OPT_EDGE_POLARITY_SELECT = 6;
  localparam int OPT_PRESCALER_ASSIGN = 3;
  localparam int OPT_PRESCALE_SEL_LSB = 0;
  localparam int ST_TIMEOUT_FLAG = 4;
  localparam int ST_POWERDOWN_FLAG = 3;
  localparam int ST_ASLEEP = 0;
  localparam logic [7:0] INTERRUPT_CONTROL_RST = 8'h00;
  localparam logic [7:0] PERIPHERAL_IRQ_FLAGS_RST = 8'h00;
  localparam logic [7:0] OPTION_CONTROL_RST = 8'hFF;
  localparam logic [7:0] PERIPHERAL_IRQ_ENABLES_RST = 8'h00;
  localparam logic [7:0] PERIPHERAL_MASK = 8'h40;
  localparam logic [12:0] IRQ_VECTOR = 13'h0004;

  // ****************************************************************
  // Timing.
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 20;
  localparam int WDT_OSC_PERIOD_NS = 1000;
  localparam int WDT_BASE_PERIOD_US = 18000;
  localparam int WDT_OSC_DIV = WDT_OSC_PERIOD_NS / CLK_PERIOD_NS;
  localparam int WDT_CNT_W = 24;
  localparam logic [WDT_CNT_W-1:0] WDT_BASE_TICKS_DEF =
    WDT_CNT_W'(WDT_BASE_PERIOD_US * 1000 / WDT_OSC_PERIOD_NS);
  localparam logic [1:0] WAKE_DUMMY_CYCLES = 2'h2;

  // ****************************************************************
  // Carrier types.
  // ****************************************************************
  typedef enum logic [1:0] {ST_RUN, ST_SLEEP, ST_WAKE_EXEC, ST_WAKE_DUMMY} wsw_state_t;

  typedef struct packed {
    logic clear_watchdog_instr;
    logic sleep_instr;
    logic instr_end;
  } wsw_core_in_t;

  typedef struct packed {
    logic osc_run;
    logic io_hold;
    logic prefetch_next;
    logic resume;
    logic dummy_cycle;
    logic vector_load;
    logic push_return;
    logic [12:0] vector_addr;
  } wsw_core_out_t;

  typedef struct packed {
    logic edge_interrupt_pin;
    logic port_change;
    logic timer_overflow;
    logic comparator;
  } wsw_events_t;

endpackage : wsw_pkg

/* logic/wsw_watchdog_sleep.sv */
// Watchdog timer, sleep entry and wake-up control with interrupt flag registers.
// Assumes an APB requester on pclk, a processor core giving instruction strobes,
// and synchronous event inputs; the external reset pin is sampled, never driven.
//
// Added by the designer: the APB interface to the registers.

`timescale 1ns/1ps

module wsw_watchdog_sleep #(
  parameter logic [wsw_pkg::WDT_CNT_W-1:0] WDT_BASE_TICKS = wsw_pkg::WDT_BASE_TICKS_DEF
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB completer.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [wsw_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Configuration and external reset pin.
  input wire logic watchdog_config_enable,
  input wire logic external_reset_pin_n,
  // Processor core.
  input wire wsw_pkg::wsw_core_in_t core_in,
  output wsw_pkg::wsw_core_out_t core_out,
  output logic device_reset,
  // Interrupt sources.
  input wire wsw_pkg::wsw_events_t events
);
  import wsw_pkg::*;

  // ****************************************************************
  // State.
  // ****************************************************************
  typedef struct packed {
    wsw_state_t fsm;
    logic [7:0] interrupt_control;
    logic [7:0] peripheral_irq_flags;
    logic [7:0] option_control;
    logic [7:0] peripheral_irq_enables;
    logic timeout_flag;
    logic powerdown_flag;
    logic [6:0] osc_div;
    logic [6:0] ps_cnt;
    logic [WDT_CNT_W-1:0] wdt_cnt;
    logic edge_pin_prev;
    logic [1:0] dummy_cnt;
    logic [31:0] prdata;
    logic device_reset;
    wsw_core_out_t core;
  } wsw_regs_t;

  wsw_regs_t s;
  wsw_regs_t next_s;

  // ****************************************************************
  // Helpers.
  // ****************************************************************

  // True when a byte address selects the register at the given index.
  function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
    reg_hit = (a == {2'b00, idx, 2'b00});
  endfunction : reg_hit

  // Terminal prescaler count for a 1:2^sel division.
  function automatic logic [6:0] ps_limit(input logic [2:0] sel);
    logic [7:0] full;
    full = 8'h01 << sel;
    ps_limit = 7'(full - 8'h01);
  endfunction : ps_limit

  // Address decode shared by reads and writes.
  logic hit_status;
  logic hit_ic;
  logic hit_pf;
  logic hit_opt;
  logic hit_pe;
  logic mapped;

  assign hit_status = reg_hit(paddr, IDX_STATUS);
  assign hit_ic = reg_hit(paddr, IDX_INTERRUPT_CONTROL);
  assign hit_pf = reg_hit(paddr, IDX_PERIPHERAL_IRQ_FLAGS);
  assign hit_opt = reg_hit(paddr, IDX_OPTION_CONTROL);
  assign hit_pe = reg_hit(paddr, IDX_PERIPHERAL_IRQ_ENABLES);
  assign mapped = hit_status | hit_ic | hit_pf | hit_opt | hit_pe;

  // Zero-wait completer; unmapped addresses answer with an error.
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign prdata = s.prdata;
  assign core_out = s.core;
  assign device_reset = s.device_reset;

  // ****************************************************************
  // Next-state logic.
  // ****************************************************************
  logic osc_tick;
  logic wdt_step;
  logic wdt_expire;
  logic wdt_clear;
  logic prescaler_assign;
  logic edge_seen;
  logic pending;
  logic wake;
  logic take_irq;
  logic wr;

  // Builds the next copy of the whole state in one pass.
  always_comb begin
    next_s = s;
    osc_tick = 1'b0;
    wdt_step = 1'b0;
    wdt_expire = 1'b0;
    wdt_clear = 1'b0;
    wake = 1'b0;
    take_irq = 1'b0;
    prescaler_assign = s.option_control[OPT_PRESCALER_ASSIGN];
    wr = psel & penable & pwrite & pready;

    // Single-cycle outputs fall back to idle.
    next_s.core.prefetch_next = 1'b0;
    next_s.core.resume = 1'b0;
    next_s.core.vector_load = 1'b0;
    next_s.core.push_return = 1'b0;
    next_s.device_reset = 1'b0;

    // Read data is captured in the setup phase so it is a flop in the access phase.
    if (psel && !penable && !pwrite) begin
      next_s.prdata = 32'h0000_0000;
      if (hit_status) begin
        next_s.prdata[ST_TIMEOUT_FLAG] = s.timeout_flag;
        next_s.prdata[ST_POWERDOWN_FLAG] = s.powerdown_flag;
        next_s.prdata[ST_ASLEEP] = (s.fsm == ST_SLEEP);
      end else if (hit_ic) begin
        next_s.prdata[7:0] = s.interrupt_control;
      end else if (hit_pf) begin
        next_s.prdata[7:0] = s.peripheral_irq_flags;
      end else if (hit_opt) begin
        next_s.prdata[7:0] = s.option_control;
      end else if (hit_pe) begin
        next_s.prdata[7:0] = s.peripheral_irq_enables;
      end
    end

    // Software writes; the status register ignores writes.
    if (wr && hit_ic) begin
      next_s.interrupt_control = pwdata[7:0];
    end
    if (wr && hit_pf) begin
      next_s.peripheral_irq_flags = pwdata[7:0] & PERIPHERAL_MASK;
    end
    if (wr && hit_opt) begin
      next_s.option_control = pwdata[7:0];
    end
    if (wr && hit_pe) begin
      next_s.peripheral_irq_enables = pwdata[7:0] & PERIPHERAL_MASK;
    end

    // Event flags set after the write so an event beats a clear in the same cycle.
    next_s.edge_pin_prev = events.edge_interrupt_pin;
    edge_seen = (events.edge_interrupt_pin != s.edge_pin_prev) &&
                (events.edge_interrupt_pin == s.option_control[OPT_EDGE_POLARITY_SELECT]);
    if (edge_seen) begin
      next_s.interrupt_control[IC_EDGE_PIN_FLAG] = 1'b1;
    end
    if (events.port_change) begin
      next_s.interrupt_control[IC_PORT_CHANGE_FLAG] = 1'b1;
    end
    if (events.timer_overflow) begin
      next_s.interrupt_control[IC_TIMER_OVERFLOW_FLAG] = 1'b1;
    end
    if (events.comparator) begin
      next_s.peripheral_irq_flags[PF_COMPARATOR] = 1'b1;
    end

    // A source is pending when its own flag and enable are set, the comparator also needing the peripheral enable; global enable is not used.
    pending = (s.interrupt_control[IC_EDGE_PIN_FLAG] & s.interrupt_control[IC_EDGE_PIN_IRQ_ENABLE])
      | (s.interrupt_control[IC_PORT_CHANGE_FLAG] & s.interrupt_control[IC_PORT_CHANGE_IRQ_ENABLE])
      | (s.interrupt_control[IC_TIMER_OVERFLOW_FLAG]
         & s.interrupt_control[IC_TIMER_OVERFLOW_IRQ_ENABLE])
      | (s.interrupt_control[IC_PERIPHERAL_IRQ_ENABLE] & s.peripheral_irq_flags[PF_COMPARATOR]
         & s.peripheral_irq_enables[PF_COMPARATOR]);

    // Watchdog oscillator tick; free running, independent of sleep and oscillator state.
    if (s.osc_div == 7'(WDT_OSC_DIV - 1)) begin
      next_s.osc_div = 7'h00;
      osc_tick = 1'b1;
    end else begin
      next_s.osc_div = s.osc_div + 7'h01;
    end

    // Prescaler and watchdog counter.
    if (osc_tick) begin
      if (prescaler_assign) begin
        if (s.ps_cnt == ps_limit(s.option_control[OPT_PRESCALE_SEL_LSB +: 3])) begin
          next_s.ps_cnt = 7'h00;
          wdt_step = 1'b1;
        end else begin
          next_s.ps_cnt = s.ps_cnt + 7'h01;
        end
      end else begin
        wdt_step = 1'b1;
      end
    end
    if (wdt_step && watchdog_config_enable) begin
      if (s.wdt_cnt == WDT_BASE_TICKS - WDT_CNT_W'(1)) begin
        next_s.wdt_cnt = '0;
        wdt_expire = 1'b1;
      end else begin
        next_s.wdt_cnt = s.wdt_cnt + WDT_CNT_W'(1);
      end
    end
    if (wdt_expire) begin
      next_s.timeout_flag = 1'b0;
    end
    if (core_in.clear_watchdog_instr) begin
      wdt_clear = 1'b1;
    end

    // Sleep and wake-up sequencing.
    case (s.fsm)
      ST_RUN: begin
        if (core_in.sleep_instr) begin
          wdt_clear = 1'b1;
          next_s.powerdown_flag = 1'b0;
          next_s.timeout_flag = 1'b1;
          next_s.core.prefetch_next = 1'b1;
          if (pending) begin
            wake = 1'b1;
          end else begin
            next_s.fsm = ST_SLEEP;
            next_s.core.osc_run = 1'b0;
            next_s.core.io_hold = 1'b1;
          end
        end else if (s.interrupt_control[IC_GLOBAL_IRQ_ENABLE] && pending
                     && core_in.instr_end) begin
          take_irq = 1'b1;
        end
      end
      ST_SLEEP: begin
        if (wdt_expire || pending) begin
          wake = 1'b1;
        end
      end
      ST_WAKE_EXEC: begin
        if (core_in.instr_end) begin
          next_s.fsm = ST_WAKE_DUMMY;
          next_s.dummy_cnt = 2'h0;
          next_s.core.dummy_cycle = 1'b1;
        end
      end
      ST_WAKE_DUMMY: begin
        if (s.dummy_cnt == WAKE_DUMMY_CYCLES - 2'h1) begin
          next_s.core.dummy_cycle = 1'b0;
          take_irq = 1'b1;
        end else begin
          next_s.dummy_cnt = s.dummy_cnt + 2'h1;
        end
      end
      default: begin
        next_s.fsm = ST_RUN;
      end
    endcase

    // Wake-up restarts the oscillator, releases pins and picks the continuation.
    if (wake) begin
      wdt_clear = 1'b1;
      next_s.core.osc_run = 1'b1;
      next_s.core.io_hold = 1'b0;
      next_s.core.resume = 1'b1;
      if (s.interrupt_control[IC_GLOBAL_IRQ_ENABLE] && pending) begin
        next_s.fsm = ST_WAKE_EXEC;
      end else begin
        next_s.fsm = ST_RUN;
      end
    end

    // Interrupt entry: only the return address is pushed, in the same cycle as the vector load.
    if (take_irq) begin
      next_s.interrupt_control[IC_GLOBAL_IRQ_ENABLE] = 1'b0;
      next_s.core.push_return = 1'b1;
      next_s.core.vector_load = 1'b1;
      next_s.core.vector_addr = IRQ_VECTOR;
      next_s.fsm = ST_RUN;
    end

    // Watchdog and prescaler clear; prescaler only when it belongs to the watchdog.
    if (wdt_clear) begin
      next_s.wdt_cnt = '0;
      if (prescaler_assign) begin
        next_s.ps_cnt = 7'h00;
      end
    end

    // Disabled watchdog never counts; no register bit can override the strap.
    if (!watchdog_config_enable) begin
      next_s.wdt_cnt = '0;
      next_s.ps_cnt = 7'h00;
      if (s.fsm == ST_SLEEP && !pending) begin
        next_s.timeout_flag = next_s.timeout_flag;
      end
    end

    // Device resets: external pin, or expiry while running. The pin is input only.
    if (!external_reset_pin_n || (wdt_expire && watchdog_config_enable && s.fsm != ST_SLEEP)) begin
      next_s.device_reset = 1'b1;
      next_s.fsm = ST_RUN;
      next_s.interrupt_control = INTERRUPT_CONTROL_RST;
      next_s.peripheral_irq_flags = PERIPHERAL_IRQ_FLAGS_RST;
      next_s.option_control = OPTION_CONTROL_RST;
      next_s.peripheral_irq_enables = PERIPHERAL_IRQ_ENABLES_RST;
      next_s.wdt_cnt = '0;
      next_s.ps_cnt = 7'h00;
      next_s.dummy_cnt = 2'h0;
      next_s.core.osc_run = 1'b1;
      next_s.core.io_hold = 1'b0;
      next_s.core.dummy_cycle = 1'b0;
      next_s.core.prefetch_next = 1'b0;
      next_s.core.resume = 1'b0;
      next_s.core.vector_load = 1'b0;
      next_s.core.push_return = 1'b0;
    end
  end

  // ****************************************************************
  // State register.
  // ****************************************************************

  // Power-up reset sets both status flags and starts with the oscillator running.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s.fsm <= ST_RUN;
      s.interrupt_control <= INTERRUPT_CONTROL_RST;
      s.peripheral_irq_flags <= PERIPHERAL_IRQ_FLAGS_RST;
      s.option_control <= OPTION_CONTROL_RST;
      s.peripheral_irq_enables <= PERIPHERAL_IRQ_ENABLES_RST;
      s.timeout_flag <= 1'b1;
      s.powerdown_flag <= 1'b1;
      s.osc_div <= 7'h00;
      s.ps_cnt <= 7'h00;
      s.wdt_cnt <= '0;
      s.edge_pin_prev <= 1'b0;
      s.dummy_cnt <= 2'h0;
      s.prdata <= 32'h0000_0000;
      s.device_reset <= 1'b0;
      s.core <= '{osc_run: 1'b1, io_hold: 1'b0, prefetch_next: 1'b0, resume: 1'b0,
                  dummy_cycle: 1'b0, vector_load: 1'b0, push_return: 1'b0,
                  vector_addr: IRQ_VECTOR};
    end else begin
      s <= next_s;
    end
  end

endmodule : wsw_watchdog_sleep

/* verif/wsw_watchdog_sleep_assertions.sv */
// Concurrent checks on the watchdog and sleep/wake-up block.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
module wsw_chk #(
  parameter logic [wsw_pkg::WDT_CNT_W-1:0] WDT_BASE_TICKS = wsw_pkg::WDT_BASE_TICKS_DEF
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Watched ports.
  input wire logic external_reset_pin_n,
  input wire logic device_reset,
  input wire wsw_pkg::wsw_core_in_t core_in,
  input wire wsw_pkg::wsw_core_out_t core_out
);
  import wsw_pkg::*;
  localparam int MIN_Q = int'(WDT_BASE_TICKS) * WDT_OSC_DIV - 2 * WDT_OSC_DIV;
  logic [31:0] quiet;

  // *****
  // Cycles since the last clear-watchdog, sleep, wake-up or reset seen on the ports; the disabled-strap clear is not seen.
  // *****
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      quiet <= 32'h0;
    end else if (core_in.clear_watchdog_instr || core_in.sleep_instr || device_reset ||
                 core_out.resume || !external_reset_pin_n) begin
      quiet <= 32'h0;
    end else begin
      quiet <= quiet + 32'h1;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // The two steps of a sleep entry and of a vectored wake.
  sequence s_asleep;
    core_out.prefetch_next && core_out.io_hold;
  endsequence
  sequence s_dummy;
    core_out.dummy_cycle [*2];
  endsequence

  chk_sleep_entry: assert property (core_in.sleep_instr && core_out.osc_run |=>
    s_asleep or core_out.resume) else $error("sleep entry missing");
  chk_osc_hold_pair: assert property (core_out.osc_run != core_out.io_hold)
    else $error("oscillator and hold disagree");
  chk_pin_reset: assert property (!external_reset_pin_n |=> device_reset)
    else $error("pin reset missing");
  chk_sleep_no_reset: assert property (core_out.io_hold && external_reset_pin_n |=>
    !device_reset) else $error("reset while asleep");
  chk_resume_awake: assert property (core_out.resume |->
    core_out.osc_run && !core_out.io_hold && !device_reset) else $error("bad resume");
  chk_wake_vector: assert property ($rose(core_out.dummy_cycle) |->
    s_dummy ##1 (core_out.vector_load && !core_out.dummy_cycle)) else $error("bad vector");
  chk_push_pair: assert property (core_out.vector_load == core_out.push_return)
    else $error("push and vector split");
  chk_vector_addr: assert property (core_out.vector_addr == IRQ_VECTOR)
    else $error("wrong vector");
  chk_hold_release: assert property ($fell(core_out.io_hold) |->
    core_out.resume || device_reset || $past(device_reset)) else $error("hold dropped");
  chk_wdt_period: assert property (device_reset && $past(external_reset_pin_n) &&
    !$past(device_reset) |-> $past(quiet) >= MIN_Q) else $error("watchdog too early");
endmodule : wsw_chk

bind wsw_watchdog_sleep wsw_chk #(.WDT_BASE_TICKS(WDT_BASE_TICKS)) u_wsw_chk (
  .pclk(pclk), .presetn(presetn), .external_reset_pin_n(external_reset_pin_n),
  .device_reset(device_reset), .core_in(core_in), .core_out(core_out));

/* verif/wsw_core_model.sv */
// Behavioural model of the processor core and the interrupt sources.
// Assumes the testbench calls its tasks; all lines change just after rising pclk.
`timescale 1ns/1ps
module wsw_core_model (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Block side.
  input wire wsw_pkg::wsw_core_out_t core_out,
  output wsw_pkg::wsw_core_in_t core_in,
  output wsw_pkg::wsw_events_t events
);
  import wsw_pkg::*;
  logic clr_r = 1'b0;
  logic slp_r = 1'b0;
  logic end_r = 1'b0;
  logic [1:0] phase = 2'h0;
  wsw_events_t ev_r = '0;

  // Strobes and event lines as the block sees them.
  assign core_in = {clr_r, slp_r, end_r};
  assign events = ev_r;

  // Instruction boundary every fourth cycle, none while stopped or in a dummy cycle.
  always @(posedge pclk) begin
    phase <= phase + 2'h1;
    end_r <= presetn && phase == 2'h3 && core_out.osc_run && !core_out.dummy_cycle;
  end

  // Executes a sleep or clear-watchdog instruction once the core runs.
  task automatic op(input logic sleep);
    @(posedge pclk);
    while (!core_out.osc_run || core_out.dummy_cycle) @(posedge pclk);
    slp_r <= sleep;
    clr_r <= !sleep;
    @(posedge pclk);
    slp_r <= 1'b0;
    clr_r <= 1'b0;
  endtask : op

  // One-cycle event on source k: edge pin, port change, timer, comparator.
  task automatic fire(input int k);
    @(posedge pclk);
    ev_r[3-k] <= 1'b1;
    @(posedge pclk);
    ev_r <= '0;
  endtask : fire
endmodule : wsw_core_model

/* verif/wsw_watchdog_sleep_tb.sv */
// Self-checking testbench for the watchdog and sleep/wake-up block.
// Assumes the package, design, checker and core model are compiled before it.
`timescale 1ns/1ps
module wsw_watchdog_sleep_tb;
  import wsw_pkg::*;
  localparam logic [WDT_CNT_W-1:0] TICKS = 24'h000014;
  localparam int LIMIT = 60000;
  localparam logic [11:0] A_ST = {2'h0, IDX_STATUS, 2'h0};
  localparam logic [11:0] A_IC = {2'h0, IDX_INTERRUPT_CONTROL, 2'h0};
  localparam logic [11:0] A_PF = {2'h0, IDX_PERIPHERAL_IRQ_FLAGS, 2'h0};
  localparam logic [11:0] A_OP = {2'h0, IDX_OPTION_CONTROL, 2'h0};
  localparam logic [11:0] A_PE = {2'h0, IDX_PERIPHERAL_IRQ_ENABLES, 2'h0};
  localparam logic [7:0] IC_EN [4] = '{8'h10, 8'h08, 8'h20, 8'h40};
  localparam logic [7:0] IC_FL [4] = '{8'h02, 8'h01, 8'h04, 8'h00};
  localparam logic [7:0] OPTS [3] = '{8'h00, 8'h09, 8'h0A};
  logic pclk = 1'b0;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic cfg_en;
  logic pin_n;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic device_reset;
  wsw_core_in_t core_in;
  wsw_core_out_t core_out;
  wsw_events_t events;
  logic [32:0] exp_q [$];
  logic [31:0] r;
  int bad_count = 0;
  int compares = 0;
  int cyc = 0;
  int seed = 49;
  int n;

  always #10 pclk = ~pclk;

  wsw_watchdog_sleep #(.WDT_BASE_TICKS(TICKS)) u_wsw_watchdog_sleep (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .watchdog_config_enable(cfg_en), .external_reset_pin_n(pin_n), .core_in(core_in),
    .core_out(core_out), .device_reset(device_reset), .events(events));
  wsw_core_model u_wsw_core_model (
    .pclk(pclk), .presetn(presetn), .core_out(core_out), .core_in(core_in), .events(events));

  // *****
  // Compare, bus and wait helpers.
  // *****
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_val

  task automatic chk_bus(input logic [32:0] got, input logic [32:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t bus=%h exp=%h", $time, got, exp);
    end
  endtask : chk_bus

  task automatic close_out;
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : close_out

  function automatic logic mapped(input logic [11:0] a);
    return a inside {A_ST, A_IC, A_PF, A_OP, A_PE};
  endfunction : mapped

  // One APB transfer; the expected error flag and read data are queued first.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [31:0] e);
    exp_q.push_back({!mapped(a), (w || !mapped(a)) ? 32'h0 : e});
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, e);
  endtask : rd

  // Waits for reset (0), resume (1) or vector load (2); cnt equals lim if none came.
  task automatic wait_for(input int which, input int lim, output int cnt);
    logic hit;
    cnt = 0;
    do begin
      @(posedge pclk);
      #1;
      cnt++;
      hit = which == 0 ? device_reset : which == 1 ? core_out.resume : core_out.vector_load;
    end while (cnt < lim && hit !== 1'b1);
  endtask : wait_for

  // Clears halfway through one period, then times the expiry after the clear.
  task automatic wdt_run(input logic [7:0] opt);
    int p;
    p = int'(TICKS) * WDT_OSC_DIV * (opt[3] ? (1 << opt[2:0]) : 1);
    wr(A_OP, {24'h0, opt});
    wait_for(0, p / 2, n);
    chk_val(32'(n), 32'(p / 2));
    u_wsw_core_model.op(1'b0);
    wait_for(0, p + 100, n);
    chk_val(32'(n >= p - 60 && n <= p + 60), 32'h1);
    rd(A_ST, 32'h08);
    rd(A_OP, 32'hFF);
  endtask : wdt_run

  // Bus monitor: every access phase is matched against the oldest note.
  always @(posedge pclk) begin
    if (psel && penable && pready) begin
      chk_bus({pslverr, pwrite ? 32'h0 : prdata}, exp_q.pop_front());
    end
  end

  // Cycle ceiling against hangs.
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      bad_count++;
      close_out();
    end
  end

  // *****
  // Main sequence.
  // *****
  initial begin
    {psel, penable, pwrite, paddr, pwdata, presetn} <= 48'h0;
    {cfg_en, pin_n} <= 2'h3;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(A_ST, 32'h18);
    rd(A_IC, 32'h00);
    rd(A_PF, 32'h00);
    rd(A_OP, 32'hFF);
    rd(A_PE, 32'h00);
    rd(12'h010, 32'h0);
    wr(12'h010, 32'hFF);
    wr(A_ST, 32'h0);
    rd(A_ST, 32'h18);
    cfg_en <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      r = $random(seed);
      wr(A_OP, r);
      rd(A_OP, {24'h0, r[7:0]});
      wr(A_PE, r);
      rd(A_PE, r & 32'h40);
    end
    wr(A_OP, 32'h0);
    wait_for(0, 1500, n);
    chk_val(32'(n), 32'h5DC);
    cfg_en <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      wdt_run(OPTS[i]);
    end
    // Each enabled source wakes the core and continues in line.
    for (int k = 0; k < 4; k++) begin
      wr(A_PE, {24'h0, k == 3 ? 8'h40 : 8'h00});
      wr(A_IC, {24'h0, IC_EN[k]});
      u_wsw_core_model.op(1'b1);
      #1;
      chk_val({29'h0, core_out.prefetch_next, core_out.osc_run, core_out.io_hold}, 32'h5);
      rd(A_ST, 32'h11);
      u_wsw_core_model.fire(k);
      wait_for(1, 10, n);
      chk_val(32'(n < 10), 32'h1);
      wait_for(2, 12, n);
      chk_val(32'(n), 32'h0C);
      rd(A_IC, {24'h0, IC_EN[k] | IC_FL[k]});
      rd(A_PF, k == 3 ? 32'h40 : 32'h0);
      wr(A_IC, 32'h0);
      wr(A_PF, 32'h0);
    end
    // A disabled source stays asleep; the watchdog then wakes without reset.
    wr(A_OP, 32'h0);
    u_wsw_core_model.op(1'b1);
    u_wsw_core_model.fire(1);
    wait_for(1, 20, n);
    chk_val(32'(n), 32'h14);
    rd(A_IC, 32'h01);
    wait_for(1, 1200, n);
    chk_val(32'(n > 850 && n < 1060), 32'h1);
    rd(A_ST, 32'h00);
    wait_for(0, 1200, n);
    chk_val(32'(n > 900 && n < 1060), 32'h1);
    // Global enable set: wake, dummy cycles, vector and enable cleared.
    wr(A_IC, 32'h88);
    u_wsw_core_model.op(1'b1);
    u_wsw_core_model.fire(1);
    wait_for(1, 10, n);
    wait_for(2, 20, n);
    chk_val(32'(n < 20), 32'h1);
    rd(A_IC, 32'h09);
    u_wsw_core_model.op(1'b1);
    #1;
    chk_val(32'(core_out.resume), 32'h1);
    // External reset pin during sleep resets the device.
    wr(A_IC, 32'h0);
    u_wsw_core_model.op(1'b1);
    @(posedge pclk);
    pin_n <= 1'b0;
    wait_for(0, 5, n);
    pin_n <= 1'b1;
    chk_val(32'(n < 5), 32'h1);
    rd(A_ST, 32'h10);
    close_out();
  end
endmodule : wsw_watchdog_sleep_tb
